// ---- rtl/lpae_top.sv ----
`timescale 1ns/1ps
module lpae_top
  import lpae_pkg::*;
#(
  parameter int NUM_LED = 12,            // LED count
  parameter int MS_CYC  = CLK_KHZ        // Clocks per millisecond
)(
  input  wire logic                  clk,            // System clock
  input  wire logic                  rst,            // Sync reset
  input  wire logic                  chip_en,        // Device enable
  input  wire logic                  commit,         // Config commit pulse
  input  wire logic                  pwm_slow_in,    // 1 selects 12kHz
  input  wire logic                  sync_out_en_in, // Sync pin output enable
  input  wire logic [NUM_LED-1:0][1:0] align_in,     // Alignment per LED
  input  wire logic [NUM_LED-1:0]    exp_en_in,      // Exponential curve
  input  wire logic [NUM_LED-1:0]    auto_en_in,     // Autonomous mode
  input  wire logic                  lod_action_in,  // Open fault response
  input  wire logic                  lsd_action_in,  // Short fault response
  input  wire logic [NUM_LED-1:0][7:0] man_pwm,      // Manual PWM setting
  input  wire logic [NUM_LED-1:0][7:0] man_cur,      // Manual current
  input  wire logic [NUM_LED-1:0][7:0] auto_cur,     // Autonomous current
  input  wire logic [NUM_LED-1:0]    led_en,         // Autonomous LED enable
  input  lpae_pkg::lpae_anim_s [NUM_LED-1:0] anim_cfg, // Pattern setup
  input  wire logic                  start_cmd,      // Launch pulse
  input  wire logic                  stop_cmd,       // Halt pulse
  input  wire logic                  pause_cmd,      // Pause pulse
  input  wire logic                  resume_cmd,     // Resume pulse
  input  wire logic                  lod_clear,      // Open flag clear pulse
  input  wire logic                  lsd_clear,      // Short flag clear pulse
  input  wire logic [NUM_LED-1:0]    open_det,       // Cathode below open level
  input  wire logic [NUM_LED-1:0]    short_det,      // Cathode above short level
  input  wire logic                  over_temp,      // Thermal indication
  input  wire logic                  sync_i,         // Sync pin input
  output logic                       sync_o,         // Sync pin output
  output logic                       sync_oe,        // Sync pin drive enable
  output logic [NUM_LED-1:0]         led_on,         // LED PWM drive
  output logic [NUM_LED-1:0][7:0]    led_cur,        // LED current
  output lpae_pkg::lpae_dev_e        dev_state,      // Device state
  output logic [NUM_LED-1:0]         lod_flag,       // Open flags
  output logic [NUM_LED-1:0]         lsd_flag,       // Short flags
  output logic [NUM_LED-1:0][7:0]    pwm_rb,         // PWM readback
  output logic [NUM_LED-1:0][3:0]    unit_status     // Pattern unit status
);
  // Step length product must fit 40 bits, so the millisecond count is capped
  generate
    if (NUM_LED < 1 || NUM_LED > 32 || MS_CYC < 256 || MS_CYC > 1000000)
    begin : g_bad_param
      $error("lpae_top: unsupported parameters");
    end
  endgenerate

  // Committed configuration
  logic                       slow_r, sync_en_r, lod_act_r, lsd_act_r;
  logic [NUM_LED-1:0][1:0]    align_r;
  logic [NUM_LED-1:0]         exp_r, auto_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      slow_r    <= 1'b0;
      sync_en_r <= 1'b0;
      lod_act_r <= 1'b0;
      lsd_act_r <= 1'b0;
      align_r   <= '0;
      exp_r     <= '0;
      auto_r    <= '0;
    end
    else if (commit)
    begin
      slow_r    <= pwm_slow_in;
      sync_en_r <= sync_out_en_in;
      lod_act_r <= lod_action_in;
      lsd_act_r <= lsd_action_in;
      align_r   <= align_in;
      exp_r     <= exp_en_in;
      auto_r    <= auto_en_in;
    end
  end

  // Pin synchronisers
  logic [NUM_LED-1:0] op1, op_s, sh1, sh_s;
  logic               ot1, ot_s, sy1, sy_s, sy_d;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {op1, op_s, sh1, sh_s} <= '0;
      {ot1, ot_s, sy1, sy_s, sy_d} <= '0;
    end
    else
    begin
      op1 <= open_det;
      op_s <= op1;
      sh1 <= short_det;
      sh_s <= sh1;
      ot1 <= over_temp;
      ot_s <= ot1;
      sy1 <= sync_i;
      sy_s <= sy1;
      sy_d <= sy_s;
    end
  end

  // 6MHz tick by fractional accumulation; each sync edge is one tick
  logic [8:0] acc_r;
  logic       osc_tick, src_tick, half_r;
  logic [7:0] cnt_r;
  assign osc_tick = (acc_r + 9'(OSC_MHZ)) >= 9'(CLK_MHZ);
  assign src_tick = sync_en_r ? osc_tick : (sy_s ^ sy_d);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_r   <= '0;
      sync_o  <= 1'b0;
      sync_oe <= 1'b0;
      half_r  <= 1'b0;
      cnt_r   <= '0;
    end
    else
    begin
      acc_r   <= osc_tick ? 9'(acc_r + 9'(OSC_MHZ) - 9'(CLK_MHZ)) : 9'(acc_r + 9'(OSC_MHZ));
      sync_oe <= sync_en_r;
      if (osc_tick)
        sync_o <= ~sync_o;
      if (src_tick)
        half_r <= ~half_r;
      if (src_tick && (!slow_r || half_r))
        cnt_r <= cnt_r + 8'h01;
    end
  end

  // Animation commands
  logic run_r, pause_r, advance;
  always_ff @(posedge clk)
  begin
    if (rst || stop_cmd)
      run_r <= 1'b0;
    else if (start_cmd)
      run_r <= 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (rst || stop_cmd || start_cmd || resume_cmd)
      pause_r <= 1'b0;
    else if (pause_cmd)
      pause_r <= 1'b1;
  end
  assign advance = run_r && !pause_r && (dev_state == DS_NORMAL);

  function automatic logic [31:0] step_len(input logic [3:0] c);
    logic [63:0] p;
    p = 64'(T_MS[c]) * 64'(MS_CYC);
    step_len = (p[39:8] == 32'h0) ? 32'h1 : p[39:8];
  endfunction

  function automatic logic [1:0] next_unit(input logic [1:0] u, input logic [2:0][1:0] r);
    next_unit = 2'h3;
    if (u == 2'h0 && r[1] != 2'h0)
      next_unit = 2'h1;
    else if (u != 2'h2 && r[2] != 2'h0)
      next_unit = 2'h2;
  endfunction

  logic [NUM_LED-1:0][7:0] setting;
  logic [NUM_LED-1:0]      off, eff;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LED; gi++)
    begin : g_led
      lpae_anim_s  a;
      lpae_sq_e    ph_r;
      logic [1:0]  u_r, s_r, ur_r, pr_r, lu;
      logic [7:0]  step_r, val_r, b, e, val_nxt;
      logic [31:0] cyc_r;
      logic [3:0]  code;
      logic        seg_end;
      logic signed [9:0]  diff;
      logic signed [18:0] prod;
      logic signed [10:0] sum;
      assign a  = anim_cfg[gi];
      assign lu = (a.urep[2] != 2'h0) ? 2'h2 : (a.urep[1] != 2'h0) ? 2'h1 : 2'h0;

      always_comb
      begin
        case (ph_r)
          SQ_HOLD1: begin code = a.hold[0]; b = a.lvl[0][0]; e = a.lvl[0][0]; end
          SQ_FADE:  begin code = a.dur[u_r][s_r]; b = a.lvl[u_r][s_r]; e = a.lvl[u_r][s_r + 2'h1]; end
          SQ_HOLD2: begin code = a.hold[1]; b = a.lvl[lu][4]; e = a.lvl[lu][4]; end
          default:  begin code = 4'h0; b = val_r; e = val_r; end
        endcase
        seg_end = (code == 4'h0) || (step_r == 8'hFF && cyc_r >= step_len(code) - 32'h1);
        diff    = $signed({2'b00, e}) - $signed({2'b00, b});
        prod    = diff * $signed({2'b00, step_r});
        sum     = $signed({3'b000, b}) + prod[18:8];
        val_nxt = sum[7:0];
      end

      always_ff @(posedge clk)
      begin
        if (rst || stop_cmd)
        begin
          ph_r <= SQ_IDLE;
          {u_r, s_r, ur_r, pr_r} <= '0;
          step_r <= '0;
          cyc_r  <= '0;
          val_r  <= '0;
        end
        else if (start_cmd)
        begin
          ph_r <= SQ_HOLD1;
          {u_r, s_r, ur_r, pr_r} <= '0;
          step_r <= '0;
          cyc_r  <= '0;
        end
        else if (advance && ph_r != SQ_IDLE && ph_r != SQ_DONE)
        begin
          if (ph_r != SQ_FADE || code != 4'h0)
            val_r <= val_nxt;
          if (!seg_end)
          begin
            cyc_r <= (cyc_r >= step_len(code) - 32'h1) ? 32'h0 : cyc_r + 32'h1;
            if (cyc_r >= step_len(code) - 32'h1)
              step_r <= step_r + 8'h01;
          end
          else
          begin
            cyc_r  <= '0;
            step_r <= '0;
            case (ph_r)
              SQ_HOLD1: ph_r <= (a.prep == 2'h0) ? SQ_HOLD2 : SQ_FADE;
              SQ_FADE:
                if (s_r != 2'h3)
                  s_r <= s_r + 2'h1;
                else
                begin
                  s_r <= 2'h0;
                  if (a.urep[u_r] == REP_INF || ur_r + 2'h1 < a.urep[u_r])
                    ur_r <= ur_r + 2'h1;
                  else if (next_unit(u_r, a.urep) != 2'h3)
                  begin
                    ur_r <= 2'h0;
                    u_r  <= next_unit(u_r, a.urep);
                  end
                  else if (a.prep == REP_INF || pr_r + 2'h1 < a.prep)
                  begin
                    ur_r <= 2'h0;
                    u_r  <= 2'h0;
                    pr_r <= pr_r + 2'h1;
                  end
                  else
                    ph_r <= SQ_HOLD2;
                end
              SQ_HOLD2: ph_r <= SQ_DONE;
              default:  ph_r <= ph_r;
            endcase
          end
        end
      end

      assign setting[gi] = auto_r[gi] ? val_r : man_pwm[gi];
      assign eff[gi] = auto_r[gi] ? (led_en[gi] && run_r) : (man_pwm[gi] != 8'h00 && man_cur[gi] != 8'h00);
      assign off[gi] = (dev_state != DS_NORMAL) || ot_s || (lod_act_r && lod_flag[gi]);

      lpae_pwm_if pif ();
      assign pif.cnt    = cnt_r;
      assign pif.duty   = setting[gi];
      assign pif.align  = align_r[gi];
      assign pif.exp_en = exp_r[gi];
      lpae_pwm_chan u_chan (
        .clk (clk),
        .rst (rst),
        .pif (pif)
      );

      // Fault qualification counters
      logic [1:0] oc_r, sc_r;
      logic       elig;
      assign elig = (dev_state == DS_NORMAL) && (setting[gi] > DET_MIN_PWM);
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          oc_r <= '0;
          sc_r <= '0;
          lod_flag[gi] <= 1'b0;
          lsd_flag[gi] <= 1'b0;
          led_on[gi]   <= 1'b0;
          led_cur[gi]  <= '0;
          pwm_rb[gi]   <= '0;
          unit_status[gi] <= '0;
        end
        else
        begin
          oc_r <= (elig && op_s[gi]) ? ((oc_r == 2'h3) ? 2'h3 : oc_r + 2'h1) : 2'h0;
          sc_r <= (elig && sh_s[gi]) ? ((sc_r == 2'h3) ? 2'h3 : sc_r + 2'h1) : 2'h0;
          lod_flag[gi] <= (elig && op_s[gi] && oc_r == 2'(DET_CYC - 1))
                          || (lod_flag[gi] && !lod_clear && op_s[gi]);
          lsd_flag[gi] <= (elig && sh_s[gi] && sc_r == 2'(DET_CYC - 1))
                          || (lsd_flag[gi] && !lsd_clear && sh_s[gi]);
          led_on[gi]   <= pif.on && !off[gi];
          led_cur[gi]  <= off[gi] ? 8'h00 : (auto_r[gi] ? auto_cur[gi] : man_cur[gi]);
          pwm_rb[gi]   <= setting[gi];
          unit_status[gi] <= {advance && ph_r != SQ_DONE && ph_r != SQ_IDLE,
                              (ph_r == SQ_HOLD1) ? 3'h0 : (ph_r == SQ_FADE) ? 3'({1'b0, u_r} + 3'h1) :
                              (ph_r == SQ_IDLE) ? 3'h7 : 3'h4};
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      dev_state <= DS_INITIAL;
    else if (!chip_en)
      dev_state <= DS_INITIAL;
    else
      case (dev_state)
        DS_INITIAL: dev_state <= DS_STANDBY;
        DS_STANDBY: if (|eff) dev_state <= DS_NORMAL;
        DS_NORMAL:
          if (lsd_act_r && |lsd_flag)
            dev_state <= DS_FAULT;
          else if (!(|eff) || stop_cmd)
            dev_state <= DS_STANDBY;
        DS_FAULT:   if (lsd_clear) dev_state <= DS_STANDBY;
        default:    dev_state <= DS_INITIAL;
      endcase
  end

  logic elig0;
  assign elig0 = g_led[0].elig;

  sequence s_open3;
    elig0 && op_s[0] ##1 elig0 && op_s[0] ##1 elig0 && op_s[0];
  endsequence
  sequence s_short3;
    elig0 && sh_s[0] ##1 elig0 && sh_s[0] ##1 elig0 && sh_s[0];
  endsequence

  property p_open_set;
    @(posedge clk) disable iff (rst) !(elig0 && op_s[0]) ##1 s_open3 |=> lod_flag[0];
  endproperty
  a_open_set: assert property (p_open_set) else $error("open flag not set");

  property p_short_set;
    @(posedge clk) disable iff (rst) !(elig0 && sh_s[0]) ##1 s_short3 |=> lsd_flag[0];
  endproperty
  a_short_set: assert property (p_short_set) else $error("short flag not set");

  property p_open_clr;
    @(posedge clk) disable iff (rst) !op_s[0] |=> !lod_flag[0];
  endproperty
  a_open_clr: assert property (p_open_clr) else $error("open flag stuck");

  property p_fault_off;
    @(posedge clk) disable iff (rst) dev_state == DS_FAULT |=> led_on == '0 && led_cur == '0;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("LED lit in fault");

  property p_fault_exit;
    @(posedge clk) disable iff (rst) dev_state == DS_FAULT && lsd_clear && chip_en |=> dev_state == DS_STANDBY;
  endproperty
  a_fault_exit: assert property (p_fault_exit) else $error("fault not cleared");

  property p_ot_off;
    @(posedge clk) disable iff (rst) ot_s |=> led_on == '0;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("LED lit while hot");

  property p_init;
    @(posedge clk) disable iff (rst) dev_state == DS_INITIAL && chip_en |=> dev_state == DS_STANDBY;
  endproperty
  a_init: assert property (p_init) else $error("no standby after enable");

  property p_sync_oe;
    @(posedge clk) disable iff (rst) commit && sync_out_en_in |=> ##1 sync_oe;
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("sync not driven");

  property p_pause_hold;
    @(posedge clk) disable iff (rst)
    pause_r && $past(pause_r) && auto_r[0] && $past(auto_r[0]) |=> $stable(pwm_rb[0]);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("value moved while paused");
endmodule

// ---- rtl/lpae_pkg.sv ----
// Functional notes
// - 8-bit PWM, 24kHz or 12kHz select
// - PWM timebase from internal 6MHz clock when driving sync, from sync pin edges when receiving
// - Sync pin drives clock or receives it
// - Per-LED forward, middle or backward alignment
// - Per-LED exponential or linear duty curve
// - Manual follows registers; autonomous follows sequencer
// - Hold, three fades, hold; repeat counts
// - Fade units two, three skipped at zero
// - Host configures fully, then launches animation
// - PWM value and unit status readable
// - Slope ramps in 256 even steps
// - Duration code: sixteen levels, zero to eight seconds
// - Five levels, four slopes; zero slope skipped
// - Equal adjacent levels hold brightness for duration
// - Holds skip at zero, borrow neighbour levels
// - Open flag after three low cycles
// - Open flags clear on command or recovery
// - Open response bit turns faulty LED off
// - Short flag after three high cycles
// - Short response enters fault shutdown; clear exits
// - Overtemperature switches all LEDs off
// - Device state machine transitions
// - Mode config takes effect only after commit; PWM, current, enable and pattern inputs act at once
package lpae_pkg;
  localparam int       CLK_MHZ     = 250;
  localparam int       OSC_MHZ     = 6;
  localparam int       PWM_BITS    = 8;
  localparam int       CLK_KHZ     = CLK_MHZ * 1000;
  localparam int       DET_CYC     = 3;
  localparam logic [7:0] DET_MIN_PWM = 8'h19;
  localparam logic [1:0] REP_INF   = 2'h3;
  localparam logic [1:0] ALIGN_FWD = 2'h0;
  localparam logic [1:0] ALIGN_MID = 2'h1;
  localparam logic [1:0] ALIGN_BWD = 2'h2;
  // Typical slope times in milliseconds per 4-bit code
  localparam int T_MS [16] = '{0, 90, 180, 360, 540, 800, 1070, 1520,
                               2060, 2500, 3040, 4020, 5010, 5990, 7060, 8050};

  typedef enum logic [1:0] {DS_INITIAL, DS_STANDBY, DS_NORMAL, DS_FAULT} lpae_dev_e;
  typedef enum logic [2:0] {SQ_IDLE, SQ_HOLD1, SQ_FADE, SQ_HOLD2, SQ_DONE} lpae_sq_e;

  typedef struct packed {
    logic [2:0][4:0][7:0] lvl;   // fade unit levels
    logic [2:0][3:0][3:0] dur;   // fade unit slope codes
    logic [1:0][3:0]      hold;  // leading, trailing hold codes
    logic [2:0][1:0]      urep;  // unit_repeat_count
    logic [1:0]           prep;  // pattern_repeat_count
  } lpae_anim_s;
endpackage

// ---- rtl/lpae_pwm_if.sv ----
`timescale 1ns/1ps
interface lpae_pwm_if;
  logic [7:0] cnt;
  logic [7:0] duty;
  logic [1:0] align;
  logic       exp_en;
  logic       on;
  modport top  (output cnt, output duty, output align, output exp_en, input on);
  modport chan (input cnt, input duty, input align, input exp_en, output on);
endinterface

// ---- rtl/lpae_pwm_chan.sv ----
`timescale 1ns/1ps
module lpae_pwm_chan
  import lpae_pkg::*;
(
  input wire logic clk,       // System clock
  input wire logic rst,       // Sync reset
  lpae_pwm_if.chan pif        // Frame counter and setting
);
  logic [7:0] d_r;
  logic [7:0] st;
  logic       on_nxt;

  // Piecewise 2^(v/32): cheap, monotonic, no table
  function automatic logic [7:0] expo(input logic [7:0] v);
    logic [12:0] m;
    m = 13'({1'b1, v[4:0]}) << v[7:5];
    expo = (v == 8'h00) ? 8'h00 : m[12:5];
  endfunction

  always_ff @(posedge clk)
  begin
    if (rst)
      d_r <= 8'h00;
    else
      d_r <= pif.exp_en ? expo(pif.duty) : pif.duty;
  end

  always_comb
  begin
    st = 8'((9'h100 - {1'b0, d_r}) >> 1);
    case (pif.align)
      ALIGN_MID: on_nxt = ({1'b0, pif.cnt} >= {1'b0, st}) && ({1'b0, pif.cnt} < ({1'b0, st} + {1'b0, d_r}));
      ALIGN_BWD: on_nxt = {1'b0, pif.cnt} >= (9'h100 - {1'b0, d_r});
      default:   on_nxt = pif.cnt < d_r;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pif.on <= 1'b0;
    else
      pif.on <= on_nxt;
  end

  property p_fwd_on;
    @(posedge clk) disable iff (rst)
    (pif.align == ALIGN_FWD) && (pif.cnt < d_r) |=> pif.on;
  endproperty
  a_fwd_on: assert property (p_fwd_on) else $error("forward pulse missing");

  property p_bwd_off;
    @(posedge clk) disable iff (rst)
    (pif.align == ALIGN_BWD) && ({1'b0, pif.cnt} < (9'h100 - {1'b0, d_r})) |=> !pif.on;
  endproperty
  a_bwd_off: assert property (p_bwd_off) else $error("backward pulse too early");
endmodule

// ---- verif/lpae_led_model.sv ----
`timescale 1ns/1ps
module lpae_led_model #(
  parameter int N = 4
)(
  input  wire logic         clk,       // System clock
  input  wire logic         sync_o,    // Device sync output
  input  wire logic         sync_oe,   // Device drives sync wire
  input  wire logic         ext_run,   // Host sync source running
  input  wire logic [N-1:0] opn,       // LEDs broken open
  input  wire logic [N-1:0] shrt,      // LEDs shorted
  output logic              sync_i,    // Resolved sync wire
  output logic [N-1:0]      open_det,  // Cathode below open level
  output logic [N-1:0]      short_det  // Cathode above short level
);
  logic div_r = 1'b0;
  logic ext_r = 1'b0;

  // Host source backs off while the device drives, so one party only
  always @(posedge clk)
  begin
    div_r <= ~div_r;
    if (ext_run && !sync_oe && div_r)
      ext_r <= ~ext_r;
  end

  assign sync_i    = sync_oe ? sync_o : ext_r;
  assign open_det  = opn;
  assign short_det = shrt;
endmodule

// ---- verif/led_pwm_animation_engine_tb.sv ----
`timescale 1ns/1ps
module led_pwm_animation_engine_tb;
  import lpae_pkg::*;
  localparam int N = 4;
  logic clk = 1'b0, rst = 1'b1, chip_en = 1'b0, commit = 1'b0;
  logic pwm_slow_in = 1'b0, sync_out_en_in = 1'b0, lod_action_in = 1'b0, lsd_action_in = 1'b0;
  logic start_cmd = 1'b0, stop_cmd = 1'b0, pause_cmd = 1'b0, resume_cmd = 1'b0;
  logic lod_clear = 1'b0, lsd_clear = 1'b0, over_temp = 1'b0, ext_run = 1'b0;
  logic [N-1:0][1:0]  align_in = '0;
  logic [N-1:0]       exp_en_in = '0, auto_en_in = '0, led_en = '0, opn = '0, shrt = '0;
  logic [N-1:0][7:0]  man_pwm = '0, man_cur = '0, auto_cur = '0;
  lpae_anim_s [N-1:0] anim_cfg = '0;
  logic               sync_i, sync_o, sync_oe;
  logic [N-1:0]       open_det, short_det, led_on, lod_flag, lsd_flag;
  logic [N-1:0][7:0]  led_cur, pwm_rb;
  logic [N-1:0][3:0]  unit_status;
  lpae_dev_e          dev_state;
  int bad_count = 0, n_checks = 0, on_c[N], ov[4], ed0, tg, d, v;

  always #2 clk = ~clk;

  lpae_top #(.NUM_LED(N), .MS_CYC(256)) u_lpae_top (.clk, .rst, .chip_en, .commit, .pwm_slow_in,
    .sync_out_en_in, .align_in, .exp_en_in, .auto_en_in, .lod_action_in, .lsd_action_in, .man_pwm,
    .man_cur, .auto_cur, .led_en, .anim_cfg, .start_cmd, .stop_cmd, .pause_cmd, .resume_cmd,
    .lod_clear, .lsd_clear, .open_det, .short_det, .over_temp, .sync_i, .sync_o, .sync_oe,
    .led_on, .led_cur, .dev_state, .lod_flag, .lsd_flag, .pwm_rb, .unit_status);

  lpae_led_model #(.N(N)) u_lpae_led_model (.clk, .sync_o, .sync_oe, .ext_run, .opn, .shrt,
    .sync_i, .open_det, .short_det);

  task end_sim;
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      $display("[FAIL] %0t %s", $time, m);
      bad_count++;
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic wstate(input lpae_dev_e s);
    int k;
    k = 0;
    while (dev_state !== s && k < 40)
    begin
      step(1);
      k++;
    end
    chk(dev_state === s, "state not reached");
    if (dev_state !== s)
      end_sim;
  endtask

  // Window counts: on time, overlaps, LED0 rising edges, sync toggles
  task automatic meas(input int n);
    logic [N-1:0] p;
    logic         ps;
    on_c = '{default: 0};
    ov = '{default: 0};
    ed0 = 0;
    tg = 0;
    repeat (n)
    begin
      p = led_on;
      ps = sync_o;
      step(1);
      if ($isunknown(led_on))
        chk(1'b0, "unknown LED drive");
      for (int i = 0; i < N; i++)
        on_c[i] += int'(led_on[i]);
      ov[0] += int'(led_on[0] & led_on[1]);
      ov[1] += int'(led_on[0] & led_on[2]);
      ov[2] += int'(led_on[1] & led_on[2]);
      ov[3] += int'(led_on[0] & led_on[3]);
      ed0 += int'(led_on[0] & ~p[0]);
      tg += int'(sync_o ^ ps);
    end
  endtask

  function automatic logic near(input int a, input int e, input int t);
    return (a >= e - t) && (a <= e + t);
  endfunction

  initial
  begin
    v = $urandom(57935);
    step(8);
    rst = 1'b0;
    chk(dev_state === DS_INITIAL && led_on === '0, "reset state");
    chip_en = 1'b1;
    wstate(DS_STANDBY);
    // External sync: one tick per 2 clocks, so a frame is 512 clocks
    d = 26 + int'($urandom % 230);
    man_pwm = {8'(d), 8'h40, 8'h40, 8'h40};
    man_cur = {4{8'h80}};
    align_in = {ALIGN_FWD, ALIGN_MID, ALIGN_BWD, ALIGN_FWD};
    ext_run = 1'b1;
    pulse(commit);
    wstate(DS_NORMAL);
    step(1100);
    meas(2048);
    chk(near(on_c[0], 512, 6) && near(on_c[3], d * 8, 6), "duty");
    chk(ov[0] == 0 && ov[1] == 0 && ov[2] == 0, "phase overlap");
    chk(near(ov[3], ((d < 64) ? d : 64) * 8, 6) && ed0 == 4, "forward phase");
    chk(pwm_rb[3] === 8'(d) && led_cur[3] === 8'h80, "readback");
    pwm_slow_in = 1'b1;
    step(600);
    meas(2048);
    chk(ed0 == 4, "rate before commit");
    pulse(commit);
    step(1100);
    meas(2048);
    chk(ed0 == 2 && near(on_c[0], 512, 6), "slow frame");
    pwm_slow_in = 1'b0;
    exp_en_in = 4'h1;
    pulse(commit);
    step(1100);
    meas(2048);
    chk(on_c[0] < 100 && pwm_rb[0] === 8'h40, "curve");
    exp_en_in = 4'h0;
    sync_out_en_in = 1'b1;
    pulse(commit);
    step(3);
    meas(1000);
    chk(sync_oe === 1'b1 && near(tg, 24, 1), "sync out");
    sync_out_en_in = 1'b0;
    pulse(commit);
    step(3);
    chk(sync_oe === 1'b0, "sync in");
    // Open faults: LED1 sits at 25, just below eligibility
    man_pwm[1] = 8'h19;
    opn = 4'h3;
    step(10);
    chk(lod_flag === 4'h1, "open flag");
    meas(1100);
    chk(on_c[0] > 0, "open no action");
    opn = 4'h0;
    step(6);
    chk(lod_flag === 4'h0, "open recover");
    lod_action_in = 1'b1;
    pulse(commit);
    opn = 4'h1;
    step(10);
    meas(1100);
    chk(on_c[0] == 0 && lod_flag[0] === 1'b1, "open action");
    // Clear while the open persists: flag must drop and stay down
    pulse(lod_clear);
    step(2);
    chk(lod_flag === 4'h0, "open clear");
    opn = 4'h0;
    step(6);
    lod_action_in = 1'b0;
    lsd_action_in = 1'b1;
    pulse(commit);
    shrt = 4'h8;
    wstate(DS_FAULT);
    step(2);
    chk(led_on === '0 && lsd_flag[3] === 1'b1, "shutdown");
    shrt = 4'h0;
    man_pwm = '0;
    pulse(lsd_clear);
    wstate(DS_STANDBY);
    chk(lsd_flag === 4'h0, "short clear");
    man_pwm = {4{8'h40}};
    wstate(DS_NORMAL);
    over_temp = 1'b1;
    step(6);
    meas(1100);
    chk(on_c[0] + on_c[1] + on_c[2] + on_c[3] == 0 && led_cur === '0, "thermal off");
    over_temp = 1'b0;
    step(6);
    meas(1100);
    chk(on_c[3] > 0, "thermal resume");
    man_pwm = '0;
    wstate(DS_STANDBY);
    // One 90 ms slope from 0 to 255, looped forever; 90 clocks per step
    anim_cfg[0].lvl[0] = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    anim_cfg[0].dur[0] = 16'h0001;
    anim_cfg[0].urep[0] = 2'h1;
    anim_cfg[0].prep = REP_INF;
    // LED1: no lead hold, flat first slope, unit two skipped, trail hold
    anim_cfg[1].lvl[0] = {24'h000000, 8'h50, 8'h50};
    anim_cfg[1].lvl[1][4] = 8'h11;
    anim_cfg[1].lvl[2][4] = 8'hC8;
    anim_cfg[1].dur[0] = 16'h0001;
    anim_cfg[1].dur[1] = 16'h000F;
    anim_cfg[1].hold[1] = 4'h1;
    anim_cfg[1].urep = {2'h1, 2'h0, 2'h1};
    anim_cfg[1].prep = 2'h1;
    auto_cur[0] = 8'($urandom);
    auto_en_in = 4'h3;
    led_en = 4'h3;
    pulse(commit);
    pulse(start_cmd);
    wstate(DS_NORMAL);
    step(5000);
    chk(unit_status[0] === 4'h9 && unit_status[1] === 4'h9, "unit status");
    chk(pwm_rb[1] === 8'h50, "flat slope");
    chk(led_cur[0] === auto_cur[0], "auto current");
    pulse(pause_cmd);
    step(2);
    v = int'(pwm_rb[0]);
    chk(near(v, 55, 10), "slope level");
    step(1000);
    chk(pwm_rb[0] === 8'(v) && unit_status[0] === 4'h1, "paused");
    pulse(resume_cmd);
    step(1800);
    chk(near(int'(pwm_rb[0]), v + 20, 3), "slope rate");
    step(24000);
    chk(dev_state === DS_NORMAL && pwm_rb[0] < 8'h78, "loop");
    chk(unit_status[1] === 4'hC && pwm_rb[1] === 8'hC8, "skip and trail hold");
    pulse(stop_cmd);
    wstate(DS_STANDBY);
    chip_en = 1'b0;
    wstate(DS_INITIAL);
    end_sim;
  end
endmodule
